/* hdl/rtcc_pkg.sv */
package rtcc_pkg;

    // ------------------------------------------------------------
    // port map and indexed locations
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_INDEX = 16'h0070;
    localparam logic [15:0] PORT_DATA = 16'h0071;
    localparam logic [6:0] IDX_SEC = 7'h00;
    localparam logic [6:0] IDX_ALM_SEC = 7'h01;
    localparam logic [6:0] IDX_MIN = 7'h02;
    localparam logic [6:0] IDX_ALM_MIN = 7'h03;
    localparam logic [6:0] IDX_HOUR = 7'h04;
    localparam logic [6:0] IDX_ALM_HOUR = 7'h05;
    localparam logic [6:0] IDX_DOW = 7'h06;
    localparam logic [6:0] IDX_DOM = 7'h07;
    localparam logic [6:0] IDX_MON = 7'h08;
    localparam logic [6:0] IDX_YEAR = 7'h09;
    localparam logic [6:0] IDX_CTL_A = 7'h0A;
    localparam logic [6:0] IDX_CTL_B = 7'h0B;
    localparam logic [6:0] IDX_STAT_C = 7'h0C;
    localparam logic [6:0] IDX_STAT_D = 7'h0D;

    // ------------------------------------------------------------
    // field positions and encodings
    // ------------------------------------------------------------
    localparam int CTLA_PEND_BIT = 7;
    localparam logic [2:0] DIV_RUN = 3'h2;
    localparam int CTLB_INHIBIT_BIT = 7;
    localparam int CTLB_PIE_BIT = 6;
    localparam int CTLB_AIE_BIT = 5;
    localparam int CTLB_UIE_BIT = 4;
    localparam int CTLB_BIN_BIT = 2;
    localparam int CTLB_H24_BIT = 1;
    localparam int STAT_IRQF_BIT = 7;
    localparam int STAT_PF_BIT = 6;
    localparam int STAT_AF_BIT = 5;
    localparam int STAT_UF_BIT = 4;
    localparam int STATD_VALID_BIT = 7;
    localparam logic [7:0] CTLA_RESET = 8'h26;
    localparam logic [7:0] CTLB_RESET = 8'h02;
    localparam logic [7:0] ALARM_ANY = 8'hC0;

    // ------------------------------------------------------------
    // timing: the 32.768 kHz tick drives every count below
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int XTAL_HZ = 32_768;
    localparam int TICKS_PER_SEC = XTAL_HZ;
    localparam int START_DELAY_MS = 500;
    localparam int START_TICKS = XTAL_HZ * START_DELAY_MS / 1000;
    localparam int PEND_LEAD_US = 244;
    localparam int PEND_LEAD_TICKS = 8;
    localparam int UPDATE_US = 1984;
    localparam int UPDATE_TICKS = 65;
    localparam int PEND_TICKS = PEND_LEAD_TICKS + UPDATE_TICKS;

    // ------------------------------------------------------------
    // bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } rtcc_io_req_t;

endpackage : rtcc_pkg

/* hdl/rtcc_core.sv */
// Functional notes
// - timebase is 32.768 kHz crystal clock
// - three interrupt sources gated by enables
// - periodic rate 122 us to 500 ms
// - alarm once per second to once per day
// - interrupt request asserted as rising edge
// - clock reset keeps divider and field
// - divider 110b/111b holds chain in reset
// - divider 010b starts updates after 500 ms
// - unreset enable gives undetermined first update
// - ram retained, hidden while clock disabled
// - index bit 7 ignored
// - clock enabled after system reset
// - system reset keeps only the ram and time bytes
// - low battery reset deferred to power good
// - first supply power resets clock domain
// - no battery resets at power good
// - low battery, no power: reset, invalid flag
// - updates use current binary or bcd format
// - one update per second when running
// - update lasts 1984 us with pending set
// - pending flag leads update by 244 us
// - inhibit bit suppresses time updates
module rtcc_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slowCrystalIn,
    input wire logic supplyFirstOn,
    input wire logic backupBatterySense,
    input wire logic mainPowerGood,
    input wire rtcc_pkg::rtcc_io_req_t ioReq,
    output logic [7:0] ioRdata,
    output logic ioRvalid,
    output logic clockIrq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RTCC_IDLE, RTCC_LEAD, RTCC_UPD} rtcc_phase_t;
    rtcc_phase_t phase;
    logic [7:0] mem [0:127];
    logic [6:0] locationIndex;
    logic [2:0] dividerChainControl;
    logic [3:0] rateSel;
    logic [7:0] clockControlSecond;
    logic [2:0] flags;
    logic contentsValidFlag;
    logic clockReset;
    logic deferredReset;
    logic [2:0] xtalSync;
    logic [14:0] divCount;
    logic [15:0] phaseCount;
    logic [18:0] startCount;
    logic starting;
    logic powerGoodLast;
    logic slowTick;
    logic clockEnabled;
    logic writeIdx;
    logic writeData;
    logic readData;
    logic pulsePeriodic;
    logic alarmHit;
    logic [7:0] bumpSec, bumpMin, bumpHour;

    assign writeIdx = ioReq.wr && ioReq.addr == rtcc_pkg::PORT_INDEX;
    assign writeData = ioReq.wr && ioReq.addr == rtcc_pkg::PORT_DATA;
    assign readData = ioReq.rd && ioReq.addr == rtcc_pkg::PORT_DATA;
    assign clockEnabled = dividerChainControl[2:1] != 2'b11;

    // ------------------------------------------------------------
    // crystal tick: sample the slow clock, pulse on its rising edge
    // ------------------------------------------------------------
    // the first sync stage is read only by the second one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtalSync <= 3'h0;
        end else begin
            xtalSync <= {xtalSync[1:0], slowCrystalIn};
        end
    end
    assign slowTick = xtalSync[1] && !xtalSync[2];

    // ------------------------------------------------------------
    // clock-domain reset: power conditions only, never rst_n
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerGoodLast <= 1'b1; // no false power-good edge after a system reset
            deferredReset <= 1'b0;
            clockReset <= 1'b0;
        end else begin
            powerGoodLast <= mainPowerGood;
            clockReset <= 1'b0;
            if (supplyFirstOn) begin
                clockReset <= 1'b1;
            end
            if (!backupBatterySense && mainPowerGood) begin
                deferredReset <= 1'b1;
            end
            if (mainPowerGood && !powerGoodLast && (deferredReset || !backupBatterySense)) begin
                clockReset <= 1'b1;
                deferredReset <= 1'b0;
            end
            if (!backupBatterySense && !mainPowerGood) begin
                clockReset <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // index pointer, bit 7 dropped
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locationIndex <= 7'h00;
        end else if (writeIdx) begin
            locationIndex <= ioReq.wdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // control registers; divider field survives the clock reset
    // ------------------------------------------------------------
    // the rst_n value gives a running clock with no software help
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dividerChainControl <= rtcc_pkg::CTLA_RESET[6:4];
            rateSel <= rtcc_pkg::CTLA_RESET[3:0];
            clockControlSecond <= rtcc_pkg::CTLB_RESET;
        end else begin
            if (clockReset) begin
                clockControlSecond[6:4] <= 3'h0;
            end else if (writeData && locationIndex == rtcc_pkg::IDX_CTL_B) begin
                clockControlSecond <= ioReq.wdata;
            end
            if (writeData && locationIndex == rtcc_pkg::IDX_CTL_A) begin
                dividerChainControl <= ioReq.wdata[6:4];
                rateSel <= ioReq.wdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // contents-valid flag: cleared by a dead battery, set by a read
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            contentsValidFlag <= 1'b1;
        end else if (!backupBatterySense && !mainPowerGood) begin
            contentsValidFlag <= 1'b0;
        end else if (readData && locationIndex == rtcc_pkg::IDX_STAT_D) begin
            contentsValidFlag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // divider chain and start delay
    // ------------------------------------------------------------
    // a 010b write out of reset waits 500 ms; a write while running
    // keeps the old phase, so the first update lands anywhere
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 15'h0000;
            startCount <= 19'h00000;
            starting <= 1'b0;
        end else if (!clockEnabled) begin
            divCount <= 15'h0000;
            starting <= 1'b1;
            startCount <= 19'h00000;
        end else if (slowTick) begin
            divCount <= divCount + 15'h0001;
            if (starting) begin
                if (startCount == 19'(rtcc_pkg::START_TICKS - 1)) begin
                    starting <= 1'b0;
                    divCount <= 15'(rtcc_pkg::TICKS_PER_SEC - rtcc_pkg::PEND_LEAD_TICKS);
                end else begin
                    startCount <= startCount + 19'h00001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // update sequencer: lead, update, idle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= RTCC_IDLE;
            phaseCount <= 16'h0000;
        end else if (!clockEnabled) begin
            phase <= RTCC_IDLE;
        end else if (slowTick) begin
            unique case (phase)
                RTCC_IDLE: begin
                    if (!starting && dividerChainControl == rtcc_pkg::DIV_RUN
                        && !clockControlSecond[rtcc_pkg::CTLB_INHIBIT_BIT]
                        && divCount == 15'(rtcc_pkg::TICKS_PER_SEC - rtcc_pkg::PEND_LEAD_TICKS)) begin
                        phase <= RTCC_LEAD;
                        phaseCount <= 16'h0000;
                    end
                end
                RTCC_LEAD: begin
                    phaseCount <= phaseCount + 16'h0001;
                    if (phaseCount == 16'(rtcc_pkg::PEND_LEAD_TICKS - 1)) begin
                        phase <= RTCC_UPD;
                        phaseCount <= 16'h0000;
                    end
                end
                RTCC_UPD: begin
                    phaseCount <= phaseCount + 16'h0001;
                    if (phaseCount == 16'(rtcc_pkg::UPDATE_TICKS - 1)) begin
                        phase <= RTCC_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // counting helper in binary or bcd
    // ------------------------------------------------------------
    function automatic logic [7:0] bump(input logic [7:0] v, input logic bin);
        if (bin) begin
            bump = v + 8'h01;
        end else if (v[3:0] == 4'h9) begin
            bump = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bump = v + 8'h01;
        end
    endfunction

    assign bumpSec = bump(mem[rtcc_pkg::IDX_SEC], clockControlSecond[rtcc_pkg::CTLB_BIN_BIT]);
    assign bumpMin = bump(mem[rtcc_pkg::IDX_MIN], clockControlSecond[rtcc_pkg::CTLB_BIN_BIT]);
    assign bumpHour = bump(mem[rtcc_pkg::IDX_HOUR], clockControlSecond[rtcc_pkg::CTLB_BIN_BIT]);

    // ------------------------------------------------------------
    // ram and time bytes; updates happen at the end of the cycle
    // ------------------------------------------------------------
    // day and month roll over is left to software to keep this small
    logic updateDone;
    assign updateDone = slowTick && phase == RTCC_UPD
        && phaseCount == 16'(rtcc_pkg::UPDATE_TICKS - 1);
    always_ff @(posedge clk) begin // no rst_n here: system reset keeps time and ram
        if (writeData && clockEnabled && locationIndex > rtcc_pkg::IDX_STAT_D) begin
            mem[locationIndex] <= ioReq.wdata;
        end else if (writeData && locationIndex <= rtcc_pkg::IDX_YEAR) begin
            mem[locationIndex] <= ioReq.wdata;
        end else if (updateDone) begin
            // format is whatever the control bit says now
            if (bumpSec != (clockControlSecond[rtcc_pkg::CTLB_BIN_BIT] ? 8'h3C : 8'h60)) begin
                mem[rtcc_pkg::IDX_SEC] <= bumpSec;
            end else begin
                mem[rtcc_pkg::IDX_SEC] <= 8'h00;
                if (bumpMin != (clockControlSecond[rtcc_pkg::CTLB_BIN_BIT] ? 8'h3C : 8'h60)) begin
                    mem[rtcc_pkg::IDX_MIN] <= bumpMin;
                end else begin
                    mem[rtcc_pkg::IDX_MIN] <= 8'h00;
                    mem[rtcc_pkg::IDX_HOUR] <= (bumpHour == (clockControlSecond[rtcc_pkg::CTLB_BIN_BIT]
                        ? 8'h18 : 8'h24)) ? 8'h00 : bumpHour;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // alarm compare, C0h-FFh matches anything
    // ------------------------------------------------------------
    function automatic logic match(input logic [7:0] alm, input logic [7:0] cur);
        match = (alm[7:6] == 2'b11) || alm == cur;
    endfunction
    assign alarmHit = match(mem[rtcc_pkg::IDX_ALM_SEC], mem[rtcc_pkg::IDX_SEC])
        && match(mem[rtcc_pkg::IDX_ALM_MIN], mem[rtcc_pkg::IDX_MIN])
        && match(mem[rtcc_pkg::IDX_ALM_HOUR], mem[rtcc_pkg::IDX_HOUR]);

    // ------------------------------------------------------------
    // periodic tap: rate n picks divider bit n-1 (rates 1,2 alias 8,9)
    // ------------------------------------------------------------
    logic [3:0] tapSel;
    assign tapSel = (rateSel == 4'h1 || rateSel == 4'h2) ? rateSel + 4'h7 : rateSel;
    // low bits all zero once per period; the first pulse after a rate change may come early
    assign pulsePeriodic = slowTick && rateSel != 4'h0
        && (divCount & ((15'h0001 << (tapSel - 4'h1)) - 15'h0001)) == 15'h0000;

    // ------------------------------------------------------------
    // event flags: a set in the read cycle survives
    // ------------------------------------------------------------
    logic statRead;
    assign statRead = readData && locationIndex == rtcc_pkg::IDX_STAT_C;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 3'h0;
        end else begin
            flags <= statRead ? 3'h0 : flags;
            if (pulsePeriodic) begin
                flags[2] <= 1'b1;
            end
            if (updateDone) begin
                flags[0] <= 1'b1;
                if (alarmHit) begin
                    flags[1] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt request: level high means a new rising edge
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clockIrq <= 1'b0;
        end else begin
            clockIrq <= |(flags[2:0] & clockControlSecond[6:4]);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdata <= 8'h00;
            ioRvalid <= 1'b0;
        end else begin
            ioRvalid <= readData;
            if (readData) begin
                unique case (1'b1)
                    locationIndex == rtcc_pkg::IDX_CTL_A:
                        ioRdata <= {phase != RTCC_IDLE, dividerChainControl, rateSel};
                    locationIndex == rtcc_pkg::IDX_CTL_B:
                        ioRdata <= clockControlSecond;
                    locationIndex == rtcc_pkg::IDX_STAT_C:
                        ioRdata <= {|(flags[2:0] & clockControlSecond[6:4]), flags[2:0], 4'h0};
                    locationIndex == rtcc_pkg::IDX_STAT_D:
                        ioRdata <= {contentsValidFlag, 7'h00};
                    locationIndex > rtcc_pkg::IDX_STAT_D:
                        ioRdata <= clockEnabled ? mem[locationIndex] : 8'hFF;
                    default:
                        ioRdata <= mem[locationIndex];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence leadDone_s;
        phase == RTCC_LEAD ##1 phase == RTCC_UPD;
    endsequence
    index_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        writeIdx |=> locationIndex == $past(ioReq.wdata[6:0]))
        else $error("index bit 7 not dropped");
    hold_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clockEnabled |=> divCount == 15'h0000)
        else $error("divider not held in reset");
    inhibit_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (phase == RTCC_IDLE && clockControlSecond[7]) |=> phase == RTCC_IDLE)
        else $error("update started while inhibited");
    lead_then_upd_a: assert property (@(posedge clk) disable iff (!rst_n)
        leadDone_s |-> phaseCount == 16'h0000)
        else $error("lead phase wrong");
    dead_battery_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!backupBatterySense && !mainPowerGood) |=> !contentsValidFlag && clockReset)
        else $error("battery loss not reported");
    first_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        supplyFirstOn |=> clockReset)
        else $error("first power did no reset");
    irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flags[0] && clockControlSecond[4]) |=> clockIrq)
        else $error("irq not raised");
    read_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        readData |=> ioRvalid)
        else $error("read not answered");

endmodule // rtcc_core

/* tb/rtcc_host_model.sv */
module rtcc_host_model (
    input wire logic clk,
    output rtcc_pkg::rtcc_io_req_t ioReq,
    input wire logic [7:0] ioRdata,
    input wire logic ioRvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idles with no strobe
    initial ioReq = '0;

    // one strobe cycle; the released bus shows inverted values, never stale ones
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk);
        ioReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk);
        ioReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // read answer is taken while the valid pulse stands, bounded wait
    task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
        int n;
        @(negedge clk);
        ioReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk);
        ioReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
        for (n = 0; n < 4 && ioRvalid !== 1'b1; n++) @(negedge clk);
        data = (ioRvalid === 1'b1) ? ioRdata : 8'hXX;
    endtask

    // location first, then the data port
    task automatic cmos_write(input logic [7:0] idx, input logic [7:0] data);
        io_write(rtcc_pkg::PORT_INDEX, idx);
        io_write(rtcc_pkg::PORT_DATA, data);
    endtask

    task automatic cmos_read(input logic [7:0] idx, output logic [7:0] data);
        io_write(rtcc_pkg::PORT_INDEX, idx);
        io_read(rtcc_pkg::PORT_DATA, data);
    endtask

    // precise start: inhibit, hold divider, load ten bytes, pick format, run
    task automatic init_clock();
        cmos_write(8'h0B, 8'h82);
        cmos_write(8'h0A, 8'h66);
        for (int i = 0; i < 10; i++) cmos_write(8'(i), 8'(i));
        cmos_write(8'h0B, 8'h86);
        cmos_write(8'h0B, 8'h06);
        cmos_write(8'h0A, 8'h26);
    endtask
endmodule // rtcc_host_model

/* tb/rtcc_core_tb_top.sv */
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errorCnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module rtcc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_n, slowCrystalIn, supplyFirstOn, backupBatterySense, mainPowerGood;
    rtcc_pkg::rtcc_io_req_t ioReq;
    logic [7:0] ioRdata;
    logic ioRvalid, clockIrq;
    logic [7:0] rv;
    int errorCnt, samplesChecked, n;

    rtcc_core rtcc_core_i (.clk(clk), .rst_n(rst_n), .slowCrystalIn(slowCrystalIn),
        .supplyFirstOn(supplyFirstOn), .backupBatterySense(backupBatterySense),
        .mainPowerGood(mainPowerGood), .ioReq(ioReq), .ioRdata(ioRdata),
        .ioRvalid(ioRvalid), .clockIrq(clockIrq));
    rtcc_host_model rtcc_host_model_i (.clk(clk), .ioReq(ioReq), .ioRdata(ioRdata),
        .ioRvalid(ioRvalid));

    // ------------------------------------------------------------
    // clocks and watchdog
    // ------------------------------------------------------------
    // 50 ns system clock; crystal half period kept off the rising clock edges
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        slowCrystalIn = 1'b0;
        forever #7630 slowCrystalIn = ~slowCrystalIn;
    end
    // tests need under 5k cycles, so this leaves ample margin
    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        giveVerdict();
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic rdChk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        rtcc_host_model_i.cmos_read(idx, rv);
        `CHK(rv & mask, exp)
    endtask

    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        supplyFirstOn = 1'b0;
        backupBatterySense = 1'b1;
        mainPowerGood = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        rdChk(8'h0A, 8'h7F, 8'h26);
        rdChk(8'h0B, 8'hFF, 8'h02);
        $display("test reset values done");
        // bit 7 of the index must not change the location
        rtcc_host_model_i.cmos_write(8'h0E, 8'hA5);
        rdChk(8'h8E, 8'hFF, 8'hA5);
        rtcc_host_model_i.io_read(rtcc_pkg::PORT_DATA, rv);
        `CHK(rv, 8'hA5)
        $display("test index done");
        // both divider reset codes hide and protect the ram
        for (n = 6; n < 8; n++) begin
            rtcc_host_model_i.cmos_write(8'h0A, {1'b0, 3'(n), 4'h6});
            rdChk(8'h0E, 8'hFF, 8'hFF);
            rtcc_host_model_i.cmos_write(8'h0E, 8'h5A);
        end
        rtcc_host_model_i.cmos_write(8'h0A, 8'h26);
        rdChk(8'h0E, 8'hFF, 8'hA5);
        $display("test ram hiding done");
        // fastest periodic rate with its enable, then gated off
        rtcc_host_model_i.cmos_write(8'h0A, 8'h23);
        rtcc_host_model_i.cmos_write(8'h0B, 8'h42);
        for (n = 0; n < 8000 && clockIrq !== 1'b1; n++) @(negedge clk);
        `CHK(clockIrq, 1'b1)
        rdChk(8'h0C, 8'hC0, 8'hC0);
        rtcc_host_model_i.cmos_write(8'h0B, 8'h02);
        rdChk(8'h0C, 8'h80, 8'h00);
        repeat (3000) @(negedge clk);
        `CHK(clockIrq, 1'b0)
        $display("test periodic interrupt done");
        // low battery on main power waits; with power gone it resets the clock
        rtcc_host_model_i.cmos_write(8'h0B, 8'h72);
        @(negedge clk) backupBatterySense = 1'b0;
        repeat (20) @(negedge clk);
        rdChk(8'h0B, 8'hFF, 8'h72);
        mainPowerGood = 1'b0;
        repeat (20) @(negedge clk);
        // battery back first, else the dead-battery clear would beat the read
        backupBatterySense = 1'b1;
        rdChk(8'h0D, 8'h80, 8'h00);
        rdChk(8'h0D, 8'h80, 8'h80);
        rdChk(8'h0B, 8'hFF, 8'h02);
        rdChk(8'h0A, 8'h70, 8'h20);
        // the reset held back from the battery dip lands as power returns
        rtcc_host_model_i.cmos_write(8'h0B, 8'h72);
        mainPowerGood = 1'b1;
        repeat (4) @(negedge clk);
        rdChk(8'h0B, 8'hFF, 8'h02);
        $display("test battery reset done");
        // first supply power clears the enables at once
        rtcc_host_model_i.cmos_write(8'h0B, 8'h72);
        @(negedge clk) supplyFirstOn = 1'b1;
        @(negedge clk) supplyFirstOn = 1'b0;
        repeat (4) @(negedge clk);
        rdChk(8'h0B, 8'hFF, 8'h02);
        $display("test supply reset done");
        // a system reset must leave the ram alone
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rdChk(8'h0E, 8'hFF, 8'hA5);
        $display("test system reset done");
        // full software start sequence
        rtcc_host_model_i.init_clock();
        rdChk(8'h02, 8'hFF, 8'h02);
        rdChk(8'h09, 8'hFF, 8'h09);
        rdChk(8'h0B, 8'hFF, 8'h06);
        rdChk(8'h0A, 8'h7F, 8'h26);
        $display("test init sequence done");
        giveVerdict();
    end
endmodule // rtcc_core_tb_top
